// ==== bench/apb_host.sv ====
// Host side APB master for the register block.
// Assumes the slave answers with pready; the bench timeout ends any hang.
`timescale 1ns/1ps
`default_nettype none
module apb_host
(
  input  wire logic        core_clk,
  input  wire logic        pready,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Stale data never looks valid while idle
    pwdata <= ~pwdata;
  endtask : xfer
endmodule : apb_host
`default_nettype wire

// ==== bench/buffer_event_and_line_counters_tb.sv ====
// Self-checking bench for the event and counter block.
// Assumes the design sources and register header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "line_counters_regs.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module buffer_event_and_line_counters_tb;
  logic core_clk = 1'b0, rstn = 1'b0, rx_act = 1'b0, tx_act = 1'b0;
  logic [6:0] evs = 7'h00;
  logic psel, penable, pwrite, pready, pslverr, ral, tal, mbs, ddis, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  line_counters_pkg::reg16_t lco;
  logic [32:0] q[$];
  logic [32:0] exp;
  int fails = 0, tests_run = 0, cyc = 0, seed, n, m;
  always #12.5 core_clk = ~core_clk;
  apb_host host (.core_clk(core_clk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  buffer_event_and_line_counters dut (.core_clk(core_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dma_frame_done(evs[0]), .tx_accept(evs[1]),
    .tx_starved(evs[2]), .frame_dropped(evs[3]), .early_receive(evs[4]),
    .address_match(evs[5]), .collision_seen(evs[6]), .rx_frame_active(rx_act),
    .tx_frame_active(tx_act), .receiver_allow(ral), .transmitter_allow(tal),
    .modified_backoff_select(mbs), .deferral_disable(ddis), .line_control_out(lco), .irq(irq));
  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic wt(input int k);
    repeat (k) @(posedge core_clk);
  endtask : wt
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    host.xfer(1'b1, a, d);
  endtask : wr
  // Expected word noted before the access; the watcher compares it
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    q.push_back(e);
    host.xfer(1'b0, a, 16'h0000);
  endtask : rd
  task automatic pulse(input logic [6:0] msk, input int k);
    repeat (k)
    begin
      @(posedge core_clk);
      evs <= msk;
      @(posedge core_clk);
      evs <= 7'h00;
    end
  endtask : pulse
  always @(posedge core_clk)
    if (pready === 1'b1 && pwrite === 1'b0 && q.size() > 0)
    begin
      exp = q.pop_front();
      `CHK("prdata", exp, {pslverr, prdata})
    end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      fails++;
      print_verdict;
    end
  end
  initial
  begin
    seed = 83;
    wt(6);
    rstn <= 1'b1;
    rd(`OFS_EVENTS, 33'h0000C);
    rd(`OFS_MISSED, 33'h00010);
    rd(`OFS_COLLISION, 33'h00012);
    rd(`OFS_LINE_CONTROL, 33'h00013);
    rd(12'h100, 33'h100000000);
    wr(`OFS_ENABLES, 16'hFFC0);
    pulse(7'h3F, 1);
    wt(3);
    `CHK("irq", 1'b1, irq)
    rd(`OFS_EVENTS, 33'h08FCC);
    rd(`OFS_EVENTS, 33'h0000C);
    wt(3);
    `CHK("irq", 1'b0, irq)
    rd(`OFS_MISSED, {17'h0, 10'h001, 6'h10});
    n = 1 + ($unsigned($random(seed)) % 20);
    m = 1 + ($unsigned($random(seed)) % 20);
    pulse(7'h08, n);
    rd(`OFS_MISSED, {17'h0, 10'(n), 6'h10});
    rd(`OFS_MISSED, 33'h00010);
    tx_act <= 1'b1;
    pulse(7'h40, m);
    tx_act <= 1'b0;
    pulse(7'h40, 3);
    rd(`OFS_COLLISION, {17'h0, 10'(m), 6'h12});
    rd(`OFS_COLLISION, 33'h00012);
    wr(`OFS_ENABLES, 16'h2000);
    rd(`OFS_EVENTS, 33'h0040C);
    pulse(7'h08, 511);
    wt(3);
    `CHK("irq", 1'b0, irq)
    pulse(7'h08, 1);
    wt(3);
    `CHK("irq", 1'b1, irq)
    pulse(7'h08, 512);
    rd(`OFS_MISSED, 33'h00010);
    wt(3);
    `CHK("irq", 1'b0, irq)
    wr(`OFS_ENABLES, 16'h1000);
    tx_act <= 1'b1;
    pulse(7'h40, 512);
    wt(3);
    `CHK("irq", 1'b1, irq)
    rd(`OFS_COLLISION, 33'h08012);
    wt(3);
    `CHK("irq", 1'b0, irq)
    tx_act <= 1'b0;
    wr(`OFS_LINE_CONTROL, 16'h28FF);
    rd(`OFS_LINE_CONTROL, 33'h028D3);
    wt(3);
    `CHK("backoff", 1'b1, mbs)
    `CHK("deferral", 1'b1, ddis)
    `CHK("line_ctl", 16'h28D3, lco)
    `CHK("tx_allow", 1'b1, tal)
    `CHK("rx_allow", 1'b1, ral)
    rx_act <= 1'b1;
    wr(`OFS_LINE_CONTROL, 16'h2880);
    wt(3);
    `CHK("rx_allow", 1'b1, ral)
    rx_act <= 1'b0;
    wt(3);
    `CHK("rx_allow", 1'b0, ral)
    print_verdict;
  end
endmodule : buffer_event_and_line_counters_tb
bind buffer_event_and_line_counters counters_monitor mon (.core_clk(core_clk), .rstn(rstn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready), .rx_frame_active(rx_frame_active), .tx_frame_active(tx_frame_active),
  .receiver_allow(receiver_allow), .transmitter_allow(transmitter_allow),
  .modified_backoff_select(modified_backoff_select), .deferral_disable(deferral_disable),
  .line_control_out(line_control_out));
`default_nettype wire

// ==== bench/counters_monitor.sv ====
// Port checks for the event and counter block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "line_counters_regs.svh"
module counters_monitor
  import line_counters_pkg::*;
(
  input wire logic                      core_clk,
  input wire logic                      rstn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [11:0]               paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      rx_frame_active,
  input wire logic                      tx_frame_active,
  input wire logic                      receiver_allow,
  input wire logic                      transmitter_allow,
  input wire logic                      modified_backoff_select,
  input wire logic                      deferral_disable,
  input wire line_counters_pkg::reg16_t line_control_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr_line;
    pready && pwrite && paddr == `OFS_LINE_CONTROL;
  endsequence
  sequence s_rd(a);
    pready && !pwrite && paddr == a;
  endsequence
  zero_wait_a: assert property (s_setup |=> pready && psel && penable)
    else $error("access cycle not answered");
  event_id_a: assert property (s_rd(`OFS_EVENTS) |-> prdata[5:0] == `ID_EVENTS)
    else $error("event register id wrong");
  missed_id_a: assert property (s_rd(`OFS_MISSED) |-> prdata[5:0] == `ID_MISSED)
    else $error("missed counter id wrong");
  coll_id_a: assert property (s_rd(`OFS_COLLISION) |-> prdata[5:0] == `ID_COLLISION)
    else $error("collision counter id wrong");
  line_id_a: assert property (line_control_out[5:0] == `ID_LINE_CONTROL)
    else $error("line control id wrong");
  rx_finish_a: assert property (rx_frame_active && receiver_allow |=> receiver_allow)
    else $error("receiver cut mid frame");
  tx_finish_a: assert property (tx_frame_active && transmitter_allow |=> transmitter_allow)
    else $error("transmitter cut mid frame");
  backoff_copy_a: assert property (s_wr_line |-> ##2 modified_backoff_select ==
    $past(pwdata[`BIT_MOD_BACKOFF], 2))
    else $error("backoff select not following");
  defer_copy_a: assert property (s_wr_line |-> ##2 deferral_disable ==
    $past(pwdata[`BIT_DEFER_DISABLE], 2))
    else $error("deferral disable not following");
endmodule : counters_monitor
`default_nettype wire

// ==== src/buffer_event_and_line_counters.sv ====
// Buffer event flags, missed frame and collision counters, line control and enables.
// Assumes an APB master on core_clk and event strobes of one cycle from the MAC side.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "line_counters_regs.svh"
`default_nettype none
module buffer_event_and_line_counters
  import line_counters_pkg::*;
(
  input  wire  logic                    core_clk,
  input  wire  logic                    rstn,
  input  wire  logic                    psel,
  input  wire  logic                    penable,
  input  wire  logic                    pwrite,
  input  wire  logic [11:0]             paddr,
  input  wire  logic [31:0]             pwdata,
  output logic       [31:0]             prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire  logic                    dma_frame_done,
  input  wire  logic                    tx_accept,
  input  wire  logic                    tx_starved,
  input  wire  logic                    frame_dropped,
  input  wire  logic                    early_receive,
  input  wire  logic                    address_match,
  input  wire  logic                    collision_seen,
  input  wire  logic                    rx_frame_active,
  input  wire  logic                    tx_frame_active,
  output logic                          receiver_allow,
  output logic                          transmitter_allow,
  output logic                          modified_backoff_select,
  output logic                          deferral_disable,
  output line_counters_pkg::reg16_t     line_control_out,
  output logic                          irq
);
  import line_counters_pkg::*;

  reg16_t events;
  reg16_t enables;
  reg16_t line_control;
  total_t missed_frame_total;
  total_t collision_total;
  logic   miss_half_pending;
  logic   coll_half_pending;
  total_t reported_total;

  logic   setup;
  logic   access_ok;
  logic   rd_events;
  logic   rd_missed;
  logic   rd_coll;
  logic   wr_enables;
  logic   wr_line;
  logic   mapped;
  reg16_t event_set;
  wire reg16_t next_events;
  reg16_t read_word;
  logic   miss_step;
  logic   coll_step;

  // Zero wait states: answer in the access cycle
  assign setup     = psel && !penable;
  assign access_ok = psel && penable;
  assign mapped    = (paddr == `OFS_ENABLES) || (paddr == `OFS_LINE_CONTROL) ||
                     (paddr == `OFS_EVENTS) || (paddr == `OFS_MISSED) ||
                     (paddr == `OFS_COLLISION);
  assign rd_events  = access_ok && !pwrite && (paddr == `OFS_EVENTS);
  assign rd_missed  = access_ok && !pwrite && (paddr == `OFS_MISSED);
  assign rd_coll    = access_ok && !pwrite && (paddr == `OFS_COLLISION);
  assign wr_enables = access_ok && pwrite && (paddr == `OFS_ENABLES);
  assign wr_line    = access_ok && pwrite && (paddr == `OFS_LINE_CONTROL);

  // Ready is registered, so it rises on the second (access) cycle
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      pready <= 1'b0;
    else
      pready <= setup;
  end

  // Read data captured during setup, held through access
  always_comb
  begin
    read_word = 16'h0000;
    case (paddr)
      `OFS_ENABLES:      read_word = {enables[15:6], `ID_ENABLES};
      `OFS_LINE_CONTROL: read_word = line_control;
      `OFS_EVENTS:       read_word = {events[15:6], `ID_EVENTS};
      `OFS_MISSED:       read_word = {missed_frame_total, `ID_MISSED};
      `OFS_COLLISION:    read_word = {collision_total, `ID_COLLISION};
      default:           read_word = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      prdata <= 32'h0000_0000;
    else if (setup)
      prdata <= {16'h0000, read_word};
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      pslverr <= 1'b0;
    else if (setup)
      pslverr <= !mapped;
  end

  // Host sees the setup snapshot; a read takes back only what it saw
  assign reported_total = prdata[`FLAG_TOP:`FLAG_LOW];

  // Soft request is act-once: not stored in the enables
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      enables <= {10'h000, `ID_ENABLES};
    else if (wr_enables)
    begin
      enables <= {pwdata[15:7], 1'b0, `ID_ENABLES};
    end
  end

  // Strobes placed on their flag positions
  always_comb
  begin
    event_set                  = 16'h0000;
    event_set[`BIT_SOFT_IRQ]   = wr_enables && pwdata[`BIT_SOFT_IRQ];
    event_set[`BIT_DMA_DONE]   = dma_frame_done;
    event_set[`BIT_TX_ACCEPT]  = tx_accept;
    event_set[`BIT_TX_STARVED] = tx_starved;
    event_set[`BIT_DROPPED]    = frame_dropped;
    event_set[`BIT_EARLY_RX]   = early_receive;
    event_set[`BIT_ADDR_MATCH] = address_match;
  end

  // Set wins over the clear-on-read; only flags shown to the host clear,
  // so one landing in the setup cycle is not lost unreported
  generate
    for (genvar i = `FLAG_LOW; i <= `FLAG_TOP; i++)
    begin : g_flag
      assign next_events[i] = event_set[i] ||
                              (events[i] && !(rd_events && prdata[i]));
    end
  endgenerate
  assign next_events[`FLAG_LOW-1:0] = `ID_EVENTS;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      events <= {10'h000, `ID_EVENTS};
    else
      events <= next_events;
  end

  // A read in the same cycle as a step keeps that one count
  assign miss_step = frame_dropped;
  assign coll_step = collision_seen && tx_frame_active;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      missed_frame_total <= 10'h000;
    else if (rd_missed)
      missed_frame_total <= total_t'(missed_frame_total - reported_total +
                                     total_t'(miss_step));
    else if (miss_step)
      missed_frame_total <= total_t'(missed_frame_total + `TOTAL_ONE);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      collision_total <= 10'h000;
    else if (rd_coll)
      collision_total <= total_t'(collision_total - reported_total +
                                  total_t'(coll_step));
    else if (coll_step)
      collision_total <= total_t'(collision_total + `TOTAL_ONE);
  end

  // Half-range warnings held until the counter is read
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      miss_half_pending <= 1'b0;
    else if (miss_step && !rd_missed && missed_frame_total == `TOTAL_HALF)
      miss_half_pending <= 1'b1;
    else if (rd_missed)
      miss_half_pending <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      coll_half_pending <= 1'b0;
    else if (coll_step && !rd_coll && collision_total == `TOTAL_HALF)
      coll_half_pending <= 1'b1;
    else if (rd_coll)
      coll_half_pending <= 1'b0;
  end

  // Identifier bits are forced, writes cannot disturb them
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      line_control <= {10'h000, `ID_LINE_CONTROL};
    else if (wr_line)
      line_control <= {pwdata[15:6] & `LINE_CTL_MASK, `ID_LINE_CONTROL};
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      line_control_out <= {10'h000, `ID_LINE_CONTROL};
    else
      line_control_out <= line_control;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      modified_backoff_select <= 1'b0;
    else
      modified_backoff_select <= line_control[`BIT_MOD_BACKOFF];
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      deferral_disable <= 1'b0;
    else
      deferral_disable <= line_control[`BIT_DEFER_DISABLE];
  end

  // Permission drops only at a frame boundary, so a frame in flight completes
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      receiver_allow <= 1'b0;
    else if (!rx_frame_active || line_control[`BIT_RX_ENABLE])
      receiver_allow <= line_control[`BIT_RX_ENABLE];
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      transmitter_allow <= 1'b0;
    else if (!tx_frame_active || line_control[`BIT_TX_ENABLE])
      transmitter_allow <= line_control[`BIT_TX_ENABLE];
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= (|(events[`FLAG_TOP:`FLAG_LOW] & enables[`FLAG_TOP:`FLAG_LOW] &
                `IRQ_FLAG_MASK)) ||
             (events[`BIT_SOFT_IRQ]) ||
             (miss_half_pending && enables[`BIT_MISS_HALF]) ||
             (coll_half_pending && enables[`BIT_COLL_HALF]);
  end

endmodule : buffer_event_and_line_counters
`default_nettype wire

// ==== src/line_counters_pkg.sv ====
// Types shared by the event and counter block.
// Assumes the register header is included by users of the offsets.
package line_counters_pkg;
  typedef logic [15:0] reg16_t;
  typedef logic [9:0]  total_t;
endpackage : line_counters_pkg

// ==== src/line_counters_regs.svh ====
// Register offsets, field positions and reset values for the event and counter block.
// Assumes an APB slave with 32-bit data; 16-bit registers sit in the low half of each word.
`ifndef LINE_COUNTERS_REGS_SVH
`define LINE_COUNTERS_REGS_SVH
// Register indices; each register takes one word, so byte address is index times four
`define IDX_ENABLES         10'h10A
`define IDX_LINE_CONTROL    10'h112
`define IDX_EVENTS          10'h12C
`define IDX_MISSED          10'h130
`define IDX_COLLISION       10'h132
`define OFS_ENABLES         {`IDX_ENABLES, 2'h0}
`define OFS_LINE_CONTROL    {`IDX_LINE_CONTROL, 2'h0}
`define OFS_EVENTS          {`IDX_EVENTS, 2'h0}
`define OFS_MISSED          {`IDX_MISSED, 2'h0}
`define OFS_COLLISION       {`IDX_COLLISION, 2'h0}
`define ID_ENABLES          6'h0B
`define ID_EVENTS           6'h0C
`define ID_MISSED           6'h10
`define ID_COLLISION        6'h12
`define ID_LINE_CONTROL     6'h13
`define BIT_SOFT_IRQ        6
`define BIT_DMA_DONE        7
`define BIT_TX_ACCEPT       8
`define BIT_TX_STARVED      9
`define BIT_DROPPED         10
`define BIT_EARLY_RX        11
`define BIT_COLL_HALF       12
`define BIT_MISS_HALF       13
`define BIT_ADDR_MATCH      15
`define BIT_RX_ENABLE       6
`define BIT_TX_ENABLE       7
`define BIT_MOD_BACKOFF     11
`define BIT_DEFER_DISABLE   13
`define FLAG_LOW            6
`define FLAG_TOP            15
`define IRQ_FLAG_MASK       10'h2FF
`define LINE_CTL_MASK       10'h3F3
`define TOTAL_HALF          10'h1FF
`define TOTAL_ONE           10'h001
`endif
